// file: hw/bsc_sequencer.sv
// command sequencer: power-up, conversion timing, result storage and byte delivery
// assumes the serial slave and converter front end share clk; their strobes need no sync
`timescale 1ns/1ps
module bsc_sequencer #(
  parameter int unsigned POWERUP_CYC = bsc_pkg::POWERUP_CYC,
  parameter int unsigned CYC_PER_TENTH_MS = bsc_pkg::CYC_PER_TENTH_MS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic rd_req,
  input wire logic compensate_en,
  input wire bsc_pkg::bsc_meas_t meas,
  output bsc_pkg::bsc_tx_t tx,
  output logic powerup_done_flag,
  output logic conv_busy,
  output logic conv_pressure,
  output logic conv_fail,
  output logic comp_mode
);
  localparam logic [bsc_pkg::CNT_W-1:0] PU_LAST = bsc_pkg::CNT_W'(POWERUP_CYC - 1);

  bsc_pkg::bsc_regs_t q_reg;
  bsc_pkg::bsc_regs_t q_next;

  // conversion length in cycles for one oversampling code
  function automatic logic [bsc_pkg::CNT_W-1:0] conv_cycles(input logic [10:0] tenths);
    conv_cycles = bsc_pkg::CNT_W'(tenths * CYC_PER_TENTH_MS);
  endfunction : conv_cycles

  // widen a 20-bit result to the 24-bit delivery word
  function automatic logic [23:0] word24(input logic [19:0] v, input logic sgn);
    word24 = {{4{sgn & v[19]}}, v};
  endfunction : word24

  // byte idx of the frame selected by rsel, most significant byte first
  function automatic logic [7:0] frame_byte(input bsc_pkg::bsc_rsel_t rsel,
                                            input logic [2:0] idx,
                                            input logic [2:0][19:0] res);
    logic pair;
    logic first;
    logic [1:0] slot;
    logic [1:0] pos;
    logic [23:0] w;
    pair = (rsel == bsc_pkg::RS_TP) || (rsel == bsc_pkg::RS_TA);
    first = pair && (idx < 3'h3);
    slot = ((rsel == bsc_pkg::RS_TP) || (rsel == bsc_pkg::RS_P)) ?
           bsc_pkg::RES_PRESS : bsc_pkg::RES_ALT;
    if (first) begin
      slot = bsc_pkg::RES_TEMP;
    end
    pos = (idx < 3'h3) ? idx[1:0] : 2'(idx - 3'h3);
    w = word24(res[slot], slot != bsc_pkg::RES_PRESS);
    case (pos)
      2'h0: frame_byte = w[23:16];
      2'h1: frame_byte = w[15:8];
      default: frame_byte = w[7:0];
    endcase
  endfunction : frame_byte

  logic is_conv;
  logic conv_ok;
  logic [2:0] osr_f;
  logic [1:0] chan_f;
  logic [2:0] frame_len;

  // command decode; conversion fields sit below the 010 prefix
  always_comb begin
    osr_f = cmd_byte[4:2];
    chan_f = cmd_byte[1:0];
    is_conv = cmd_byte[7:5] == bsc_pkg::CONV_PREFIX;
    conv_ok = (osr_f <= bsc_pkg::OSR_LAST_VALID) &&
              ((chan_f == bsc_pkg::CHAN_TP) || (chan_f == bsc_pkg::CHAN_T));
    frame_len = ((q_reg.rsel == bsc_pkg::RS_TP) || (q_reg.rsel == bsc_pkg::RS_TA)) ?
                bsc_pkg::PAIR_BYTES : bsc_pkg::SINGLE_BYTES;
  end

  // next-state logic; soft reset overrides everything, even mid-conversion
  always_comb begin
    q_next = q_reg;
    q_next.tx.valid = 1'b0;
    q_next.tx.last = 1'b0;
    if (cmd_valid && (cmd_byte == bsc_pkg::CMD_SOFT_RST)) begin
      q_next = bsc_pkg::REGS_RESET;
    end else begin
      unique case (q_reg.st)
        bsc_pkg::ST_INIT: begin
          // single calibration pass, then asleep with the ready flag up
          if (q_reg.cnt == PU_LAST) begin
            q_next.st = bsc_pkg::ST_SLEEP;
            q_next.ready = 1'b1;
            q_next.cnt = '0;
          end else begin
            q_next.cnt = q_reg.cnt + 1'b1;
          end
        end
        bsc_pkg::ST_SLEEP: begin
          // only a recognised command wakes the sequencer
          if (cmd_valid && is_conv) begin
            if (conv_ok) begin
              q_next.st = bsc_pkg::ST_CONV;
              q_next.cnt = '0;
              q_next.chan = chan_f;
              q_next.t_end = conv_cycles(bsc_pkg::CONV_T_TENTHS[osr_f]);
              q_next.p_end = conv_cycles(bsc_pkg::CONV_TP_TENTHS[osr_f]);
              q_next.press_phase = 1'b0;
              q_next.busy = 1'b1;
              q_next.fail = 1'b0;
              q_next.comp = compensate_en;
            end else begin
              q_next.fail = 1'b1;
            end
          end else if (cmd_valid && (cmd_byte == bsc_pkg::CMD_READ_TP)) begin
            q_next.st = bsc_pkg::ST_SEND;
            q_next.rsel = bsc_pkg::RS_TP;
            q_next.idx = '0;
          end else if (cmd_valid && (cmd_byte == bsc_pkg::CMD_READ_TA)) begin
            q_next.st = bsc_pkg::ST_SEND;
            q_next.rsel = bsc_pkg::RS_TA;
            q_next.idx = '0;
          end else if (cmd_valid && (cmd_byte == bsc_pkg::CMD_READ_P)) begin
            q_next.st = bsc_pkg::ST_SEND;
            q_next.rsel = bsc_pkg::RS_P;
            q_next.idx = '0;
          end else if (cmd_valid && (cmd_byte == bsc_pkg::CMD_READ_A)) begin
            q_next.st = bsc_pkg::ST_SEND;
            q_next.rsel = bsc_pkg::RS_A;
            q_next.idx = '0;
          end
          // any other byte falls through untouched
        end
        bsc_pkg::ST_CONV: begin
          // temperature phase always runs first; pressure and altitude land together
          q_next.cnt = q_reg.cnt + 1'b1;
          if (!q_reg.press_phase && (q_reg.cnt == q_reg.t_end - 1'b1)) begin
            q_next.res[bsc_pkg::RES_TEMP] = meas.temp;
            if (q_reg.chan == bsc_pkg::CHAN_T) begin
              q_next.st = bsc_pkg::ST_SLEEP;
              q_next.busy = 1'b0;
            end else begin
              q_next.press_phase = 1'b1;
            end
          end
          if (q_reg.press_phase && (q_reg.cnt == q_reg.p_end - 1'b1)) begin
            q_next.res[bsc_pkg::RES_PRESS] = meas.press;
            q_next.res[bsc_pkg::RES_ALT] = meas.alt;
            q_next.st = bsc_pkg::ST_SLEEP;
            q_next.busy = 1'b0;
            q_next.press_phase = 1'b0;
          end
        end
        bsc_pkg::ST_SEND: begin
          // one byte per request; the frame ends by itself after its last byte
          if (rd_req) begin
            q_next.tx.valid = 1'b1;
            q_next.tx.data = frame_byte(q_reg.rsel, q_reg.idx, q_reg.res);
            q_next.tx.last = q_reg.idx == frame_len - 1'b1;
            q_next.idx = q_reg.idx + 1'b1;
            if (q_reg.idx == frame_len - 1'b1) begin
              q_next.st = bsc_pkg::ST_SLEEP;
            end
          end
        end
      endcase
    end
  end

  // state register; storage keeps its value through sleep
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= bsc_pkg::REGS_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  // outputs straight from the state register
  always_comb begin
    tx = q_reg.tx;
    powerup_done_flag = q_reg.ready;
    conv_busy = q_reg.busy;
    conv_pressure = q_reg.press_phase;
    conv_fail = q_reg.fail;
    comp_mode = q_reg.comp;
  end

  logic soft_cmd;
  assign soft_cmd = cmd_valid && (cmd_byte == bsc_pkg::CMD_SOFT_RST);

  AST_POWERUP_END: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_INIT && q_reg.cnt == PU_LAST && !soft_cmd) |=>
      (q_reg.st == bsc_pkg::ST_SLEEP && powerup_done_flag))
    else $error("power-up did not end in sleep with ready set");
  AST_READY_STAYS: assert property (@(posedge clk) disable iff (!arst_n)
    (powerup_done_flag && !soft_cmd) |=> powerup_done_flag)
    else $error("ready flag dropped without soft reset");
  AST_ONE_CAL: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st != bsc_pkg::ST_INIT && !soft_cmd) |=> q_reg.st != bsc_pkg::ST_INIT)
    else $error("calibration rerun without reset");
  AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!arst_n)
    soft_cmd |=> (q_reg.st == bsc_pkg::ST_INIT && !powerup_done_flag && !conv_busy
                  && q_reg.res == '0))
    else $error("soft reset did not clear and restart");
  // the cycle right after a frame's last byte still clears the byte pulse, so skip it
  AST_SLEEP_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_SLEEP && !cmd_valid && !tx.valid) |=> $stable(q_reg))
    else $error("left sleep without a command");
  AST_BUSY_IN_CONV: assert property (@(posedge clk) disable iff (!arst_n)
    conv_busy == (q_reg.st == bsc_pkg::ST_CONV))
    else $error("busy flag and conversion state disagree");
  AST_TEMP_FIRST: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_CONV && !q_reg.press_phase && !soft_cmd
     && q_reg.cnt != q_reg.t_end - 1'b1) |=> !conv_pressure)
    else $error("pressure phase started before temperature ended");
  AST_TEMP_STORE: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_CONV && !q_reg.press_phase && !soft_cmd
     && q_reg.cnt == q_reg.t_end - 1'b1) |=> (q_reg.res[bsc_pkg::RES_TEMP] == $past(meas.temp)))
    else $error("temperature not stored at phase end");
  AST_RES_HELD: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_SLEEP && !soft_cmd) |=> $stable(q_reg.res))
    else $error("stored results changed while asleep");
  AST_TX_ONLY_SEND: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st != bsc_pkg::ST_SEND) |=> !tx.valid)
    else $error("byte delivered outside a read frame");
  AST_BAD_CONV: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_SLEEP && cmd_valid && is_conv && !conv_ok) |=>
      (conv_fail && q_reg.st == bsc_pkg::ST_SLEEP))
    else $error("invalid conversion code was not refused");
  AST_CONV_BOUND: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_CONV) |-> (q_reg.cnt < q_reg.p_end && q_reg.t_end < q_reg.p_end))
    else $error("conversion ran past its length");
  AST_ALT_WITH_PRESS: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_CONV && q_reg.press_phase && q_reg.cnt == q_reg.p_end - 1'b1
     && !soft_cmd) |=> (q_reg.res[bsc_pkg::RES_ALT] == $past(meas.alt)
                        && q_reg.st == bsc_pkg::ST_SLEEP))
    else $error("altitude not stored with pressure");
  AST_PRESS_MSB: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_SEND && rd_req && q_reg.rsel == bsc_pkg::RS_P
     && q_reg.idx == 3'h0 && !soft_cmd) |=>
      (tx.valid && tx.data == {4'h0, q_reg.res[bsc_pkg::RES_PRESS][19:16]}))
    else $error("pressure high byte wrong");
  AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!arst_n)
    (tx.valid && tx.last) |-> (q_reg.idx == frame_len && q_reg.st == bsc_pkg::ST_SLEEP))
    else $error("frame length wrong");
  AST_IGNORE: assert property (@(posedge clk) disable iff (!arst_n)
    (q_reg.st == bsc_pkg::ST_SLEEP && cmd_valid && !is_conv && !soft_cmd
     && cmd_byte != bsc_pkg::CMD_READ_TP && cmd_byte != bsc_pkg::CMD_READ_TA
     && cmd_byte != bsc_pkg::CMD_READ_P && cmd_byte != bsc_pkg::CMD_READ_A
     && !tx.valid) |=>
      $stable(q_reg))
    else $error("unknown command changed state");

  COV_TP_DONE: cover property (@(posedge clk) disable iff (!arst_n)
    $fell(conv_pressure) && q_reg.st == bsc_pkg::ST_SLEEP);
  COV_PAIR_READ: cover property (@(posedge clk) disable iff (!arst_n)
    tx.last && q_reg.idx == bsc_pkg::PAIR_BYTES);
  COV_RESET_MID_CONV: cover property (@(posedge clk) disable iff (!arst_n)
    soft_cmd && q_reg.st == bsc_pkg::ST_CONV);
  // temperature-only run and a refused code, the two other main paths
  COV_T_ONLY: cover property (@(posedge clk) disable iff (!arst_n)
    $fell(conv_busy) && !conv_pressure && q_reg.chan == bsc_pkg::CHAN_T);
  COV_BAD_CODE: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(conv_fail));
endmodule : bsc_sequencer

// file: pkg/bsc_pkg.sv
// constants, types and state layout of the pressure sensor command sequencer
// assumes one 25 MHz clock shared with the serial slave and the converter front end
// Notes on behaviour
// - after power-on reset run initialisation, about 400 us, then enter sleep.
// - ready flag reads 1 once the power-up sequence has completed.
// - while idle stay asleep; leave sleep only on a valid command.
// - calibrate only once per power-up or reset, then wait asleep.
// - after any accepted command finishes, return to sleep.
// - pressure conversion always runs a temperature conversion first; temperature alone allowed.
// - results are kept in storage that holds its contents while asleep.
// - conversion time follows oversampling, 2.1 ms up to 131.1 ms.
// - altitude is readable as soon as its pressure measurement completes.
// - command 0x06 resets at once, abandoning any operation.
// - soft reset clears storage except trim memory, then reruns power-up.
// - conversion command is 010, 3-bit oversampling field, 2-bit channel field.
// - channel 00 means temperature plus pressure, 10 means temperature only.
// - oversampling codes 000 to 101 select 4096 down to 128.
// - channel 01/11 or oversampling 110/111 make the conversion fail.
// - command 0x10 returns temperature then pressure.
// - command 0x11 returns temperature then altitude.
// - command 0x30 returns pressure only, 0x31 altitude only.
// - temperature is 24 bits, low 20 signed in hundredths of a degree.
// - pressure is 24 bits, low 20 unsigned, host divides by 100.
// - altitude is 24 bits, low 20 signed in hundredths of a metre.
// - a read frame returns three bytes, or six for paired commands.
package bsc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned T_POWERUP_NS = 400_000;
  localparam int unsigned POWERUP_CYC = (T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_TENTH_MS_NS = 100_000;
  localparam int unsigned CYC_PER_TENTH_MS = T_TENTH_MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 22;
  // command bytes and fields
  localparam logic [7:0] CMD_SOFT_RST = 8'h06;
  localparam logic [7:0] CMD_READ_TP = 8'h10;
  localparam logic [7:0] CMD_READ_TA = 8'h11;
  localparam logic [7:0] CMD_READ_P = 8'h30;
  localparam logic [7:0] CMD_READ_A = 8'h31;
  localparam logic [2:0] CONV_PREFIX = 3'h2;
  localparam logic [2:0] OSR_LAST_VALID = 3'h5;
  localparam logic [1:0] CHAN_TP = 2'h0;
  localparam logic [1:0] CHAN_T = 2'h2;
  // conversion times in tenths of a millisecond, indexed by oversampling code
  localparam logic [5:0][10:0] CONV_T_TENTHS =
    {11'h015, 11'h029, 11'h052, 11'h0a4, 11'h148, 11'h290};
  localparam logic [5:0][10:0] CONV_TP_TENTHS =
    {11'h029, 11'h052, 11'h0a4, 11'h148, 11'h290, 11'h51f};
  // result storage slots and read frame lengths
  localparam logic [1:0] RES_TEMP = 2'h0;
  localparam logic [1:0] RES_PRESS = 2'h1;
  localparam logic [1:0] RES_ALT = 2'h2;
  localparam logic [2:0] PAIR_BYTES = 3'h6;
  localparam logic [2:0] SINGLE_BYTES = 3'h3;

  typedef enum logic [1:0] {ST_INIT = 2'b00, ST_SLEEP = 2'b01, ST_CONV = 2'b11,
                            ST_SEND = 2'b10} bsc_state_t;
  typedef enum logic [1:0] {RS_TP, RS_TA, RS_P, RS_A} bsc_rsel_t;

  typedef struct packed {
    logic [19:0] temp;
    logic [19:0] press;
    logic [19:0] alt;
  } bsc_meas_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } bsc_tx_t;

  typedef struct packed {
    bsc_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] t_end;
    logic [CNT_W-1:0] p_end;
    logic [1:0] chan;
    logic press_phase;
    logic [2:0][19:0] res;
    bsc_rsel_t rsel;
    logic [2:0] idx;
    bsc_tx_t tx;
    logic ready;
    logic busy;
    logic fail;
    logic comp;
  } bsc_regs_t;

  localparam bsc_regs_t REGS_RESET = '0;
endpackage : bsc_pkg

// file: testbench/bsc_host_model.sv
// host model: sends single command bytes and reads result frames byte by byte
// assumes the sequencer samples its inputs on the rising edge of clk
`timescale 1ns/1ps
module bsc_host_model (
  input wire logic clk,
  input wire bsc_pkg::bsc_tx_t tx,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic rd_req
);
  // idle state of the command lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    rd_req = 1'b0;
  end

  // one write frame per command byte, the address phase is already done
  task automatic send_cmd(input logic [7:0] b);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_byte = ~b; // stale byte inverted so it cannot pass for a fresh one
  endtask : send_cmd

  // back-to-back byte requests; bytes pack msb first, flags record valid and last
  task automatic read_frame(input int n, output logic [47:0] d, output logic [5:0] vb,
                            output logic [5:0] lb);
    d = '0;
    vb = '0;
    lb = '0;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      if (i > 0) begin
        d = {d[39:0], tx.data};
        vb[i-1] = tx.valid;
        lb[i-1] = tx.last;
      end
      rd_req = (i < n);
    end
  endtask : read_frame
endmodule : bsc_host_model

// file: testbench/test_baro_sensor_command_sequencer.sv
// self-checking bench of the command sequencer with shortened power-up and time base
// assumes the host model drives commands on the falling edge; meas comes from the bench
`timescale 1ns/1ps
module test_baro_sensor_command_sequencer;
  localparam int unsigned PU = 20;
  localparam int T_TAB[6] = '{656, 328, 164, 82, 41, 21};
  localparam int TP_TAB[6] = '{1311, 656, 328, 164, 82, 41};
  logic clk;
  logic arst_n;
  logic compensate_en;
  logic cmd_valid;
  logic rd_req;
  logic [7:0] cmd_byte;
  bsc_pkg::bsc_meas_t meas;
  bsc_pkg::bsc_tx_t tx;
  logic powerup_done_flag;
  logic conv_busy;
  logic conv_pressure;
  logic conv_fail;
  logic comp_mode;
  int errors;
  int check_count;
  logic [47:0] fr;
  logic [5:0] vb;
  logic [5:0] lb;
  logic [19:0] mt;
  logic [19:0] mp;
  logic [19:0] ma;
  logic [63:0] rnd;

  bsc_sequencer #(.POWERUP_CYC(PU), .CYC_PER_TENTH_MS(1)) u_bsc_sequencer (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .rd_req(rd_req), .compensate_en(compensate_en), .meas(meas), .tx(tx),
    .powerup_done_flag(powerup_done_flag), .conv_busy(conv_busy),
    .conv_pressure(conv_pressure), .conv_fail(conv_fail), .comp_mode(comp_mode));

  bsc_host_model u_bsc_host_model (
    .clk(clk), .tx(tx), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .rd_req(rd_req));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // signed results widen by their sign bit
  function automatic logic [23:0] sx(input logic [19:0] v);
    return {{4{v[19]}}, v};
  endfunction : sx

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // send one command and read its frame; the frame flags must mark n bytes and a final last
  task automatic read_check(input logic [7:0] c, input int n, input logic [47:0] exp);
    u_bsc_host_model.send_cmd(c);
    u_bsc_host_model.read_frame(n, fr, vb, lb);
    check(fr, exp, "frame data");
    check({vb, lb}, {(6'h01 << n) - 6'h01, 6'h01 << (n - 1)}, "frame flags");
  endtask : read_check

  // run one conversion with fresh random inputs and time the whole busy run and its temperature phase
  task automatic convert(input logic [2:0] oversampling_ratio, input logic [1:0] ch);
    int nb;
    int nt;
    logic ec;
    nb = 0;
    nt = 0;
    rnd = {$urandom, $urandom};
    meas = rnd[59:0];
    ec = 1'($urandom);
    compensate_en = ec;
    u_bsc_host_model.send_cmd({3'b010, oversampling_ratio, ch});
    check(conv_fail, 1'b0, "fail cleared");
    while (conv_busy === 1'b1 && nb < 2000) begin
      nb++;
      if (conv_pressure !== 1'b1)
        nt++;
      @(negedge clk);
    end
    check(nb, ch == 2'b00 ? TP_TAB[oversampling_ratio] : T_TAB[oversampling_ratio], "busy length");
    check(nt, T_TAB[oversampling_ratio], "temperature phase first");
    check(comp_mode, ec, "compensation latched");
    mt = meas.temp;
    if (ch == 2'b00) begin
      mp = meas.press;
      ma = meas.alt;
    end
    rnd = {$urandom, $urandom};
    meas = rnd[59:0]; // front end moves on while results must stay stored
  endtask : convert

  // stop a hung run
  initial begin
    repeat (20000) @(negedge clk);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(16219));
    arst_n = 1'b0;
    compensate_en = 1'b0;
    meas = '0;
    errors = 0;
    check_count = 0;
    mt = '0;
    mp = '0;
    ma = '0;
    repeat (6) @(negedge clk);
    check({powerup_done_flag, conv_busy, tx.valid}, 3'b000, "outputs in reset");
    arst_n = 1'b1;
    u_bsc_host_model.send_cmd(8'h54);
    check(conv_busy, 1'b0, "command during power-up");
    repeat (PU - 3) @(negedge clk);
    check(powerup_done_flag, 1'b0, "ready too early");
    @(negedge clk);
    check(powerup_done_flag, 1'b1, "ready after power-up");
    $display("test powerup done");
    // invalid channel and oversampling codes
    foreach (T_TAB[i]) begin
      if (i < 4) begin
        u_bsc_host_model.send_cmd(i[1] ? {5'b01011, i[0], 2'b10} : {6'b010101, i[0], 1'b1});
        check({conv_fail, conv_busy}, 2'b10, "invalid conversion");
      end
    end
    $display("test invalid codes done");
    // unknown bytes start nothing and leave no frame to read
    u_bsc_host_model.send_cmd(8'h32);
    u_bsc_host_model.send_cmd(8'h28);
    check(conv_busy, 1'b0, "unknown byte");
    u_bsc_host_model.read_frame(3, fr, vb, lb);
    check({vb, lb}, 12'h000, "read without command");
    $display("test unknown bytes done");
    // every oversampling code on both channels, results read back by all commands
    for (int i = 0; i < 12; i++) begin
      convert(3'(i % 6), i < 6 ? 2'b00 : 2'b10);
      read_check(8'h10, 6, {sx(mt), 4'h0, mp});
      read_check(8'h11, 6, {sx(mt), sx(ma)});
      read_check(8'h30, 3, {24'h0, 4'h0, mp});
      read_check(8'h31, 3, {24'h0, sx(ma)});
    end
    $display("test conversions done");
    repeat (50) @(negedge clk);
    check({conv_busy, powerup_done_flag}, 2'b01, "idle sleep");
    // soft reset in mid conversion
    u_bsc_host_model.send_cmd(8'h40);
    repeat (10) @(negedge clk);
    u_bsc_host_model.send_cmd(8'h06);
    check({conv_busy, powerup_done_flag}, 2'b00, "soft reset abandons");
    for (int i = 0; i < PU + 5 && powerup_done_flag !== 1'b1; i++)
      @(negedge clk);
    check(powerup_done_flag, 1'b1, "power-up after soft reset");
    read_check(8'h10, 6, 48'h0);
    $display("test soft reset done");
    print_verdict();
  end
endmodule : test_baro_sensor_command_sequencer
